/* File: pccsc_pkg.sv */
`default_nettype none
package pccsc_pkg;
    // Configuration offsets (byte addresses)
    localparam logic [7:0] PCCSC_CMDST_OFF = 8'h04;
    localparam logic [7:0] PCCSC_CLASS_OFF = 8'h08;
    // Command bit positions
    localparam int PCCSC_IO_BIT = 0;
    localparam int PCCSC_MEM_BIT = 1;
    localparam int PCCSC_BME_BIT = 2;
    localparam int PCCSC_PAR_BIT = 6;
    localparam int PCCSC_SERR_BIT = 8;
    // Status bit positions
    localparam int PCCSC_CAP_BIT = 20;
    localparam int PCCSC_FB2B_BIT = 23;
    localparam int PCCSC_DPR_BIT = 24;
    localparam int PCCSC_DEVSEL_LSB = 25;
    localparam int PCCSC_TABT_BIT = 28;
    localparam int PCCSC_MABT_BIT = 29;
    localparam int PCCSC_SSE_BIT = 30;
    localparam int PCCSC_PERR_BIT = 31;
    // Class code fields
    localparam int PCCSC_BASE_LSB = 24;
    localparam int PCCSC_SUB_LSB = 16;
    localparam int PCCSC_REV_LSB = 4;
    localparam logic [7:0] PCCSC_BASE_CLASS = 8'h02;
    localparam logic [7:0] PCCSC_SUB_CLASS = 8'h00;
    localparam logic [1:0] PCCSC_DEVSEL_MEDIUM = 2'h1;
    // Values after hardware reset
    localparam logic PCCSC_IO_RST = 1'b1;
    localparam logic PCCSC_MEM_RST = 1'b1;
    localparam logic PCCSC_BME_RST = 1'b1;
    localparam logic PCCSC_PAR_RST = 1'b0;
    localparam logic PCCSC_SERR_RST = 1'b1;
    localparam logic [31:0] PCCSC_W1C_MASK = 32'hf100_0000;

    // One configuration cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pccsc_cfg_req_s;

    // Bus events seen by the PCI engine
    typedef struct packed {
        logic addr_par_err;
        logic data_par_err;
        logic perr_driven;
        logic perr_seen;
        logic master_active;
        logic master_abort;
        logic target_abort;
    } pccsc_evt_s;

    // Whole register state
    typedef struct packed {
        logic io_ctl;
        logic mem_en;
        logic bme;
        logic par_en;
        logic serr_en;
        logic perr_flag;
        logic sse_flag;
        logic mabt_flag;
        logic tabt_flag;
        logic dpr_flag;
        logic serr_out;
        logic rvalid;
        logic [31:0] rdata;
    } pccsc_state_s;
endpackage : pccsc_pkg
`default_nettype wire

/* File: pccsc_regs.sv */
// Function
// - Parity error flag sets on any detected parity error, regardless of bit 6.
// - System error signalled flag sets whenever the device drives SERR#.
// - Master abort flag sets when own master transaction ends in master abort.
// - Target abort flag sets when a target aborts own master transaction.
// - DEVSEL timing field reads 01, medium decode, and target uses it.
// - Data parity reported sets only as master, parity enabled, and PERR# driven or seen.
// - Bit 23 always reads 1, fast back-to-back target capable.
// - Bit 20 follows control register eighteen bit 19, capability list present.
// - With bits 8 and 6 set, drive SERR# on address-phase parity error.
// - Bit 6 resets 0; 1 lets parity errors raise SERR# (with bit 8) and set bit 24, 0 does not.
// - Bus mastering allowed only while bit 2 is 1; resets to 1.
// - Memory-space target access only while bit 1 is 1; resets to 1.
// - Bit 0: 0 enables, 1 disables I/O space access; resets to 1.
// - Class register bits 31 to 24 read 02h, network controller.
// - Class register bits 23 to 16 read 00h, Ethernet controller.
// - Bits 7 to 4 hold read-only revision; bits 15 to 8 reserved.
// - Defaults load on hardware reset; software reset leaves registers unchanged.
// - Byte, word and doubleword accesses honour byte enables.
`timescale 1ns/1ps
`default_nettype none
module pccsc_regs
    import pccsc_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h3 // Arbitrary value
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Configuration cycles
    input wire pccsc_cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // Bus events and capability strap
    input wire pccsc_evt_s evt,
    input wire logic cap_list_en,
    // Controls to the PCI engine
    output logic serr_active,
    output logic master_enable,
    output logic mem_access_enable,
    output logic io_access_enable,
    output logic [1:0] devsel_timing
);

    pccsc_state_s st_q;
    pccsc_state_s st_d;
    logic [31:0] cmdst_rd;
    logic [31:0] class_rd;
    logic [31:0] wmask;
    logic hit_cmdst;
    logic hit_class;
    logic serr_fire;

    // Byte enables to bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : be_mask

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hit

    always_comb
    begin
        hit_cmdst = hit(cfg_req.addr, PCCSC_CMDST_OFF);
        hit_class = hit(cfg_req.addr, PCCSC_CLASS_OFF);
        wmask = be_mask(cfg_req.be) & cfg_req.wdata & {32{cfg_req.wr & hit_cmdst}};
        // Address parity error raises SERR# only with both enables
        serr_fire = evt.addr_par_err & st_q.serr_en & st_q.par_en;
        cmdst_rd = 32'h0000_0000;
        cmdst_rd[PCCSC_PERR_BIT] = st_q.perr_flag;
        cmdst_rd[PCCSC_SSE_BIT] = st_q.sse_flag;
        cmdst_rd[PCCSC_MABT_BIT] = st_q.mabt_flag;
        cmdst_rd[PCCSC_TABT_BIT] = st_q.tabt_flag;
        cmdst_rd[PCCSC_DEVSEL_LSB +: 2] = PCCSC_DEVSEL_MEDIUM;
        cmdst_rd[PCCSC_DPR_BIT] = st_q.dpr_flag;
        cmdst_rd[PCCSC_FB2B_BIT] = 1'b1;
        cmdst_rd[PCCSC_CAP_BIT] = cap_list_en;
        cmdst_rd[PCCSC_SERR_BIT] = st_q.serr_en;
        cmdst_rd[PCCSC_PAR_BIT] = st_q.par_en;
        cmdst_rd[PCCSC_BME_BIT] = st_q.bme;
        cmdst_rd[PCCSC_MEM_BIT] = st_q.mem_en;
        cmdst_rd[PCCSC_IO_BIT] = st_q.io_ctl;
        class_rd = 32'h0000_0000;
        class_rd[PCCSC_BASE_LSB +: 8] = PCCSC_BASE_CLASS;
        class_rd[PCCSC_SUB_LSB +: 8] = PCCSC_SUB_CLASS;
        class_rd[PCCSC_REV_LSB +: 4] = REVISION;
    end

    always_comb
    begin
        st_d = st_q;
        // Command bits, byte-lane qualified
        if (cfg_req.wr && hit_cmdst && cfg_req.be[0])
        begin
            st_d.io_ctl = cfg_req.wdata[PCCSC_IO_BIT];
            st_d.mem_en = cfg_req.wdata[PCCSC_MEM_BIT];
            st_d.bme = cfg_req.wdata[PCCSC_BME_BIT];
            st_d.par_en = cfg_req.wdata[PCCSC_PAR_BIT];
        end
        if (cfg_req.wr && hit_cmdst && cfg_req.be[1])
        begin
            st_d.serr_en = cfg_req.wdata[PCCSC_SERR_BIT];
        end
        // Sticky flags: the set wins over a write-one clear
        st_d.perr_flag = (st_q.perr_flag & ~wmask[PCCSC_PERR_BIT])
            | evt.data_par_err | evt.addr_par_err;
        st_d.sse_flag = (st_q.sse_flag & ~wmask[PCCSC_SSE_BIT]) | st_q.serr_out;
        st_d.mabt_flag = (st_q.mabt_flag & ~wmask[PCCSC_MABT_BIT])
            | (evt.master_abort & evt.master_active);
        st_d.tabt_flag = (st_q.tabt_flag & ~wmask[PCCSC_TABT_BIT])
            | (evt.target_abort & evt.master_active);
        st_d.dpr_flag = (st_q.dpr_flag & ~wmask[PCCSC_DPR_BIT])
            | ((evt.perr_driven | evt.perr_seen) & evt.master_active & st_q.par_en);
        st_d.serr_out = serr_fire;
        // Read data, one cycle after the request
        st_d.rvalid = cfg_req.rd;
        st_d.rdata = 32'h0000_0000;
        if (cfg_req.rd && hit_cmdst)
        begin
            st_d.rdata = cmdst_rd & be_mask(cfg_req.be);
        end
        else if (cfg_req.rd && hit_class)
        begin
            st_d.rdata = class_rd & be_mask(cfg_req.be);
        end
    end

    // Only the hardware reset loads defaults
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.io_ctl <= PCCSC_IO_RST;
            st_q.mem_en <= PCCSC_MEM_RST;
            st_q.bme <= PCCSC_BME_RST;
            st_q.par_en <= PCCSC_PAR_RST;
            st_q.serr_en <= PCCSC_SERR_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign cfg_rdata = st_q.rdata;
    assign cfg_rvalid = st_q.rvalid;
    assign serr_active = st_q.serr_out;
    assign master_enable = st_q.bme;
    assign mem_access_enable = st_q.mem_en;
    assign io_access_enable = ~st_q.io_ctl;
    assign devsel_timing = PCCSC_DEVSEL_MEDIUM;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_parity_flag_set: assert property (evt.data_par_err |=> st_q.perr_flag)
        else $error("parity flag not set");
    a_sse_follows_serr: assert property (serr_active |=> st_q.sse_flag)
        else $error("system error flag not set");
    a_mabt_set: assert property (evt.master_abort && evt.master_active |=> st_q.mabt_flag)
        else $error("master abort flag not set");
    a_tabt_set: assert property (evt.target_abort && evt.master_active |=> st_q.tabt_flag)
        else $error("target abort flag not set");
    a_devsel_read: assert property (cfg_req.rd && hit_cmdst && cfg_req.be[3]
        |=> cfg_rdata[26:25] == 2'h1 && cfg_rdata[27] == 1'b0)
        else $error("devsel timing wrong");
    a_dpr_needs_enable: assert property (!$past(st_q.par_en) && !$past(st_q.dpr_flag) |-> !st_q.dpr_flag)
        else $error("data parity reported without enable");
    a_dpr_set: assert property (evt.master_active && st_q.par_en && (evt.perr_driven || evt.perr_seen)
        |=> st_q.dpr_flag)
        else $error("data parity reported flag not set");
    a_addr_par_flag: assert property (evt.addr_par_err |=> st_q.perr_flag)
        else $error("address parity flag not set");
    a_rvalid_pulse: assert property (cfg_req.rd |=> cfg_rvalid)
        else $error("read answer missing");
    a_rdata_idle: assert property (!cfg_req.rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
        else $error("read data stands without a read");
    a_fb2b_cap_read: assert property (cfg_req.rd && hit_cmdst && cfg_req.be[2]
        |=> cfg_rdata[23] && cfg_rdata[20] == $past(cap_list_en))
        else $error("fast b2b or capability bit wrong");
    a_serr_on_addr: assert property (evt.addr_par_err && st_q.serr_en && st_q.par_en
        |=> serr_active ##1 st_q.sse_flag)
        else $error("serr not raised");
    a_serr_gated: assert property (!st_q.par_en |=> !serr_active)
        else $error("serr raised while parity response off");
    a_bme_write: assert property (cfg_req.wr && hit_cmdst && cfg_req.be[0] && !cfg_req.wdata[2]
        |=> !master_enable)
        else $error("master enable not cleared");
    a_io_polarity: assert property (cfg_req.wr && hit_cmdst && cfg_req.be[0]
        |=> io_access_enable == !$past(cfg_req.wdata[0]) && mem_access_enable == $past(cfg_req.wdata[1]))
        else $error("space enable polarity wrong");
    a_class_read: assert property (cfg_req.rd && hit_class && cfg_req.be == 4'hf
        |=> cfg_rdata[31:16] == 16'h0200 && cfg_rdata[15:8] == 8'h00 && cfg_rdata[3:0] == 4'h0)
        else $error("class code read wrong");
    a_w1c_clear: assert property (cfg_req.wr && hit_cmdst && cfg_req.be[3] && cfg_req.wdata[29]
        && !(evt.master_abort && evt.master_active) |=> !st_q.mabt_flag)
        else $error("write one did not clear");
    a_be_ignored: assert property (cfg_req.wr && hit_cmdst && !cfg_req.be[1]
        |=> st_q.serr_en == $past(st_q.serr_en))
        else $error("disabled byte lane written");

    c_serr_seen: cover property (evt.addr_par_err ##1 serr_active ##1 st_q.sse_flag);
    c_dpr_set: cover property (!st_q.dpr_flag ##1 st_q.dpr_flag);
    c_flag_cleared: cover property (st_q.tabt_flag ##1 !st_q.tabt_flag);
    c_class_read: cover property (cfg_req.rd && hit_class ##1 cfg_rvalid);
endmodule : pccsc_regs
`default_nettype wire

/* File: pccsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pccsc_host
    import pccsc_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Configuration cycles
    output pccsc_cfg_req_s cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    initial cfg_req = '0;
    // Released lines show inverted junk
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge ref_clk);
        #1 cfg_req = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
        @(posedge ref_clk);
        #1 cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [3:0] be, output logic [31:0] d, output logic ok);
        @(posedge ref_clk);
        #1 cfg_req = '{rd: 1'b1, wr: 1'b0, addr: a, be: be, wdata: ~cfg_req.wdata};
        @(posedge ref_clk);
        #1 cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: cfg_req.wdata};
        ok = cfg_rvalid;
        d = cfg_rdata;
    endtask : rd
endmodule : pccsc_host
`default_nettype wire

/* File: pci_config_cmd_status_class_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pci_config_cmd_status_class_tb;
    import pccsc_pkg::*;
    localparam logic [3:0] REV = 4'h5;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cap_list_en = 1'b0;
    pccsc_evt_s evt = '0;
    pccsc_cfg_req_s cfg_req;
    logic [31:0] cfg_rdata, rd_v, rnd, ef;
    logic [31:0] flags_m = '0;
    logic [8:0] cmd_m = 9'h107;
    logic cfg_rvalid, serr_active, master_enable, mem_access_enable, io_access_enable;
    logic [1:0] devsel_timing;
    int err_total = 0, checks_done = 0, seed = 76894, i;
    initial forever #2 ref_clk = ~ref_clk;
    pccsc_regs #(.REVISION(REV)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .evt(evt), .cap_list_en(cap_list_en),
        .serr_active(serr_active), .master_enable(master_enable), .mem_access_enable(mem_access_enable),
        .io_access_enable(io_access_enable), .devsel_timing(devsel_timing));
    pccsc_host host (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    function automatic logic [31:0] cs_exp(input logic [3:0] b);
        logic [31:0] v;
        v = flags_m | 32'h0280_0000 | {11'h0, cap_list_en, 11'h0, cmd_m};
        return v & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction : cs_exp
    function automatic logic [31:0] ev_flags(input pccsc_evt_s e);
        return {e.addr_par_err | e.data_par_err, e.addr_par_err & cmd_m[8] & cmd_m[6],
            e.master_abort & e.master_active, e.target_abort & e.master_active, 3'h0,
            e.master_active & cmd_m[6] & (e.perr_driven | e.perr_seen), 24'h0};
    endfunction : ev_flags
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [3:0] b, input logic [31:0] exp, input string n);
        logic ok;
        host.rd(a, b, rd_v, ok);
        chk(n, {31'h0, ok}, 32'h1);
        chk(n, rd_v, exp);
    endtask : rd_chk
    task automatic cmd_wr(input logic [3:0] b, input logic [31:0] d);
        host.wr(PCCSC_CMDST_OFF, b, d);
        if (b[0]) cmd_m[7:0] = d[7:0] & 8'h47;
        if (b[1]) cmd_m[8] = d[8];
        if (b[3]) flags_m = flags_m & ~(d & 32'hf100_0000);
    endtask : cmd_wr
    task automatic pulse(input pccsc_evt_s e);
        @(posedge ref_clk);
        #1 evt = e;
        @(posedge ref_clk);
        #1 evt = '0;
    endtask : pulse
    task automatic enables;
        chk("enables", {29'h0, master_enable, mem_access_enable, io_access_enable},
            {29'h0, cmd_m[2], cmd_m[1], ~cmd_m[0]});
        chk("devsel", {30'h0, devsel_timing}, 32'h1);
    endtask : enables
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        rd_chk(PCCSC_CMDST_OFF, 4'hf, 32'h0280_0107, "reset");
        enables();
        host.wr(PCCSC_CLASS_OFF, 4'hf, 32'hffff_ffff);
        rd_chk(PCCSC_CLASS_OFF, 4'hf, {8'h02, 8'h00, 8'h00, REV, 4'h0}, "class");
        rd_chk(8'h0c, 4'hf, 32'h0, "unmapped");
        cmd_wr(4'h1, 32'h0);
        enables();
        cmd_wr(4'h3, 32'hffff_ffff);
        pulse(7'h40);
        chk("serr", {31'h0, serr_active}, 32'h1);
        flags_m = 32'hc000_0000;
        rd_chk(PCCSC_CMDST_OFF, 4'hf, cs_exp(4'hf), "par");
        for (i = 0; i < 40; i++)
        begin
            rnd = $random(seed);
            cmd_wr(rnd[3:0], $random(seed));
            enables();
            rnd = $random(seed);
            ef = ev_flags(rnd[6:0]);
            pulse(rnd[6:0]);
            chk("serr", {31'h0, serr_active}, {31'h0, ef[30]});
            flags_m = flags_m | ef;
            cap_list_en = rnd[7];
            rnd = $random(seed);
            rd_chk(PCCSC_CMDST_OFF, rnd[3:0], cs_exp(rnd[3:0]), "status");
        end
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
endmodule : pci_config_cmd_status_class_tb
`default_nettype wire
